/* File: hw/throw_freefall_detector.sv */
// throw-up and free-fall detector working on corrected three-axis samples
//
// Notes on behaviour
// - subtract 500 so 0 g reads zero
// - large departure from average starts a move
// - comparison value is sample minus stopped average
// - rising when signed current exceeds signed previous
// - while rising, current shifts into previous
// - first failed rise freezes previous as basis
// - turn-down candidate: signed current below signed basis
// - candidate must persist at least 20 ms
// - confirm only if change from basis large
// - confirmed turn-down latches basis as maximum
// - stillness: consecutive sample difference at most threshold
// - stillness must persist 120 ms before stop
// - stop records still-interval average per axis
// - composite is root of summed axis squares
// - near-zero composite, Z minus at start: throw-up
// - near-zero composite, Z plus at start: free-fall
`timescale 1ns/1ps
module throw_freefall_detector
    import throw_ff_pkg::*;
#(
    parameter int STILL_LEN = STILL_SAMPLES,
    parameter int TURN_LEN = TURN_SAMPLES
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic sample_valid,
    input wire logic [ADC_W-1:0] x_raw,
    input wire logic [ADC_W-1:0] y_raw,
    input wire logic [ADC_W-1:0] z_raw,
    input wire logic [11:0] still_thr,
    input wire logic [11:0] move_thr,
    input wire logic [11:0] turn_delta,
    input wire logic [10:0] fall_thr,
    output logic stopped_q,
    output logic moving_q,
    output logic [1:0] move_axis_q,
    output logic move_minus_q,
    output logic z_minus_q,
    output logic signed [12:0] wave_max_q,
    output logic wave_max_valid_q,
    output logic [10:0] composite_q,
    output logic throw_up_q,
    output logic free_fall_q
);
    // a run of STILL_LEN samples holds STILL_LEN-1 still steps; the sum then covers STILL_LEN
    localparam logic [CNT_W-1:0] STILL_LAST = CNT_W'(STILL_LEN - 2);
    localparam logic [CNT_W-1:0] TURN_LAST = CNT_W'(TURN_LEN - 1);
    localparam logic signed [SUM_W-1:0] STILL_DIV = SUM_W'(STILL_LEN);

    // magnitude of a signed difference
    function automatic logic [12:0] mag(input wide_t v);
        mag = v[12] ? 13'(-v) : 13'(v);
    endfunction : mag

    // apply the move direction sign before comparing
    function automatic wide_t signed_dir(input wide_t v, input logic minus);
        signed_dir = minus ? wide_t'(-v) : v;
    endfunction : signed_dir

    // bit-serial square root, one trial per result bit
    function automatic logic [10:0] isqrt(input logic [21:0] v);
        logic [10:0] root;
        logic [10:0] trial;
        logic [21:0] sq;
        root = '0;
        for (int b = 10; b >= 0; b--) begin
            trial = root | (11'h001 << b);
            sq = 22'(trial) * 22'(trial);
            if (sq <= v) begin
                root = trial;
            end
        end
        isqrt = root;
    endfunction : isqrt

    state_t state_q;
    logic [ADC_W-1:0] raw [3];
    wide_t corr [3];
    wide_t last_q [3];
    wide_t avg_q [3];
    wide_t dev [3];
    logic signed [SUM_W-1:0] sum_q [3];
    logic signed [SUM_W-1:0] sum_nx [3];
    logic signed [SUM_W-1:0] avg_nx [3];
    logic signed [25:0] prod [3];
    logic [3:0] axis_still;
    logic [2:0] axis_moved;
    logic have_last_q;
    logic [CNT_W-1:0] still_cnt_q;
    logic [CNT_W-1:0] turn_cnt_q;
    wide_t prev_q;
    wide_t basis_q;
    wide_t cur;
    logic [21:0] sq_sum;
    logic [10:0] comp_nx;
    logic still_step;
    logic still_done;
    logic [1:0] sel_axis;

    assign raw[0] = x_raw;
    assign raw[1] = y_raw;
    assign raw[2] = z_raw;

    // per-axis correction, stillness and departure tests
    for (genvar i = 0; i < 3; i++) begin : g_axis
        assign corr[i] = wide_t'({3'b000, raw[i]}) - wide_t'({3'b000, ZERO_G_CODE});
        assign dev[i] = corr[i] - avg_q[i];
        assign axis_still[i] = mag(corr[i] - last_q[i]) <= 13'(still_thr);
        assign axis_moved[i] = mag(dev[i]) > 13'(move_thr);
        assign sum_nx[i] = sum_q[i] + SUM_W'(corr[i]);
        assign avg_nx[i] = sum_nx[i] / STILL_DIV;
        assign prod[i] = corr[i] * corr[i];
    end
    assign axis_still[3] = have_last_q;

    // the first sample after reset has no predecessor, so it cannot count as still
    assign still_step = sample_valid && (&axis_still);
    assign still_done = still_step && (still_cnt_q == STILL_LAST);
    assign sq_sum = prod[0][21:0] + prod[1][21:0] + prod[2][21:0];
    assign comp_nx = isqrt(sq_sum);
    assign sel_axis = axis_moved[0] ? 2'h0 : (axis_moved[1] ? 2'h1 : 2'h2);
    assign cur = dev[move_axis_q];

    // still-run length and running sums; a finished run restarts, so continued stillness fires stop again after each full run
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            have_last_q <= 1'b0;
            still_cnt_q <= '0;
            for (int i = 0; i < 3; i++) begin
                last_q[i] <= '0;
                sum_q[i] <= '0;
                avg_q[i] <= '0;
            end
        end else if (sample_valid) begin
            have_last_q <= 1'b1;
            for (int i = 0; i < 3; i++) begin
                last_q[i] <= corr[i];
                if (still_step && !still_done) begin
                    sum_q[i] <= sum_nx[i];
                end else begin
                    sum_q[i] <= SUM_W'(corr[i]);
                end
                if (still_done) begin
                    avg_q[i] <= avg_nx[i][12:0];
                end
            end
            if (still_step && !still_done) begin
                still_cnt_q <= still_cnt_q + CNT_W'(1);
            end else begin
                still_cnt_q <= '0;
            end
        end
    end

    // composite value follows every sample
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            composite_q <= '0;
        end else if (sample_valid) begin
            composite_q <= comp_nx;
        end
    end

    // motion sequencer: stop, move start, rise, turn-down, move end
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_SETTLE;
            prev_q <= '0;
            basis_q <= '0;
            turn_cnt_q <= '0;
            move_axis_q <= 2'h0;
            move_minus_q <= 1'b0;
            z_minus_q <= 1'b0;
            wave_max_q <= '0;
            wave_max_valid_q <= 1'b0;
            throw_up_q <= 1'b0;
            free_fall_q <= 1'b0;
        end else begin
            throw_up_q <= 1'b0;
            free_fall_q <= 1'b0;
            if (sample_valid) begin
                case (state_q)
                    ST_SETTLE: begin
                        if (still_done) begin
                            state_q <= ST_IDLE;
                        end
                    end
                    ST_IDLE: begin
                        // a refreshed average replaces a move start in the same step
                        if (!still_done && (|axis_moved)) begin
                            move_axis_q <= sel_axis;
                            move_minus_q <= dev[sel_axis][12];
                            z_minus_q <= dev[2][12];
                            prev_q <= dev[sel_axis];
                            wave_max_q <= '0;
                            wave_max_valid_q <= 1'b0;
                            state_q <= ST_RISE;
                        end
                    end
                    default: begin
                        if (still_done) begin
                            // move end: near-zero composite means weightless flight
                            if (comp_nx <= fall_thr) begin
                                throw_up_q <= z_minus_q;
                                free_fall_q <= !z_minus_q;
                            end
                            state_q <= ST_IDLE;
                        end else if (state_q == ST_RISE) begin
                            if (signed_dir(cur, move_minus_q) >
                                signed_dir(prev_q, move_minus_q)) begin
                                prev_q <= cur;
                            end else begin
                                basis_q <= prev_q;
                                turn_cnt_q <= (signed_dir(cur, move_minus_q) <
                                    signed_dir(prev_q, move_minus_q)) ? CNT_W'(1) : '0;
                                state_q <= ST_TURN;
                            end
                        end else if (state_q == ST_TURN) begin
                            if (signed_dir(cur, move_minus_q) <
                                signed_dir(basis_q, move_minus_q)) begin
                                if (turn_cnt_q == TURN_LAST) begin
                                    turn_cnt_q <= '0;
                                    // a shallow dip is not a turn-down; keep watching
                                    if (mag(cur - basis_q) >= 13'(turn_delta)) begin
                                        wave_max_q <= basis_q;
                                        wave_max_valid_q <= 1'b1;
                                        state_q <= ST_GLIDE;
                                    end
                                end else begin
                                    turn_cnt_q <= turn_cnt_q + CNT_W'(1);
                                end
                            end else begin
                                turn_cnt_q <= '0;
                            end
                        end
                    end
                endcase
            end
        end
    end

    // state flags decoded into registers so outputs stay glitch free
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            stopped_q <= 1'b0;
            moving_q <= 1'b0;
        end else begin
            stopped_q <= (state_q == ST_IDLE);
            moving_q <= (state_q == ST_RISE) || (state_q == ST_TURN) || (state_q == ST_GLIDE);
        end
    end
endmodule : throw_freefall_detector

/* File: hw/throw_ff_pkg.sv */
// constants and types shared by the throw and free-fall detector
package throw_ff_pkg;
    localparam int ADC_W = 10;
    localparam logic [9:0] ZERO_G_CODE = 10'h1F4; // converter reading at 0 g (500)
    localparam int SAMPLE_PERIOD_US = 4000;
    localparam int STILL_MS = 120;
    localparam int TURN_MS = 20;
    // least times round up to whole samples; the still run spans that many intervals
    localparam int STILL_SAMPLES = (STILL_MS * 1000 + SAMPLE_PERIOD_US - 1) / SAMPLE_PERIOD_US + 1;
    localparam int TURN_SAMPLES = (TURN_MS * 1000 + SAMPLE_PERIOD_US - 1) / SAMPLE_PERIOD_US;
    localparam logic [11:0] STILL_THR_RST = 12'h014; // 20
    localparam logic [11:0] MOVE_THR_RST = 12'h01E; // 30
    localparam logic [11:0] TURN_DELTA_RST = 12'h005; // 5
    localparam logic [10:0] FALL_THR_RST = 11'h032; // 50
    localparam int CNT_W = 8;
    localparam int SUM_W = 18;
    typedef logic signed [12:0] wide_t;
    typedef enum logic [4:0] {
        ST_SETTLE = 5'b00001,
        ST_IDLE = 5'b00010,
        ST_RISE = 5'b00100,
        ST_TURN = 5'b01000,
        ST_GLIDE = 5'b10000
    } state_t;
endpackage : throw_ff_pkg

/* File: bench/adc_model.sv */
// converter model feeding raw sample codes, offset by the 0 g reading, to the detector
`timescale 1ns/1ps
module adc_model
    import throw_ff_pkg::*;
#(
    parameter int PERIOD = 4
) (
    input wire logic ref_clk,
    input wire logic signed [10:0] x_c,
    input wire logic signed [10:0] y_c,
    input wire logic signed [10:0] z_c,
    output logic sample_valid = 1'b0,
    output logic [9:0] x_raw = 10'h1F4,
    output logic [9:0] y_raw = 10'h1F4,
    output logic [9:0] z_raw = 10'h1F4
);
    int cnt = 0;
    // one set per period; between sets the codes flip so stale data is never trusted
    always @(negedge ref_clk) begin
        cnt <= (cnt + 1) % PERIOD;
        sample_valid <= (cnt == 0);
        x_raw <= (cnt == 0) ? 10'(x_c) + ZERO_G_CODE : ~x_raw;
        y_raw <= (cnt == 0) ? 10'(y_c) + ZERO_G_CODE : ~y_raw;
        z_raw <= (cnt == 0) ? 10'(z_c) + ZERO_G_CODE : ~z_raw;
    end
endmodule : adc_model

/* File: bench/throw_ff_properties.sv */
// port-level assertions for the throw and free-fall detector
`timescale 1ns/1ps
module throw_ff_properties (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic sample_valid,
    input wire logic [10:0] fall_thr,
    input wire logic stopped_q,
    input wire logic moving_q,
    input wire logic z_minus_q,
    input wire logic signed [12:0] wave_max_q,
    input wire logic wave_max_valid_q,
    input wire logic [10:0] composite_q,
    input wire logic throw_up_q,
    input wire logic free_fall_q
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_throw_single: assert property (throw_up_q |=> !throw_up_q) else $error("long throw");
    a_fall_single: assert property (free_fall_q |=> !free_fall_q) else $error("long fall");
    a_event_excl: assert property (!(throw_up_q && free_fall_q)) else $error("both events");
    a_throw_cond: assert property (throw_up_q |-> z_minus_q && composite_q <= fall_thr)
        else $error("bad throw");
    a_fall_cond: assert property (free_fall_q |-> !z_minus_q && composite_q <= fall_thr)
        else $error("bad fall");
    a_event_stops: assert property (throw_up_q || free_fall_q |=> stopped_q && !moving_q)
        else $error("no stop");
    a_event_sample: assert property (throw_up_q || free_fall_q |-> $past(sample_valid))
        else $error("event off step");
    a_comp_hold: assert property (!$past(sample_valid) |-> $stable(composite_q))
        else $error("composite moved");
    a_max_hold: assert property (wave_max_valid_q && $past(wave_max_valid_q)
        |-> $stable(wave_max_q)) else $error("max moved");
    a_move_step: assert property ($rose(moving_q) |-> $past(sample_valid, 2) && !stopped_q)
        else $error("move off step");
endmodule : throw_ff_properties

bind throw_freefall_detector throw_ff_properties chk (.ref_clk(ref_clk), .rst(rst),
    .sample_valid(sample_valid), .fall_thr(fall_thr), .stopped_q(stopped_q),
    .moving_q(moving_q), .z_minus_q(z_minus_q), .wave_max_q(wave_max_q),
    .wave_max_valid_q(wave_max_valid_q), .composite_q(composite_q),
    .throw_up_q(throw_up_q), .free_fall_q(free_fall_q));

/* File: bench/tb_throw_freefall_detector.sv */
// self-checking bench for the throw and free-fall detector
`timescale 1ns/1ps
module tb_throw_freefall_detector;
    import throw_ff_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic signed [10:0] x_c = '0, y_c = '0, z_c = '0;
    logic sample_valid, stopped_q, moving_q, move_minus_q, z_minus_q;
    logic wave_max_valid_q, throw_up_q, free_fall_q;
    logic [9:0] x_raw, y_raw, z_raw;
    logic [1:0] move_axis_q;
    logic signed [12:0] wave_max_q;
    logic [10:0] composite_q;
    logic [16:0] lfsr = 17'h14F41;
    int err_count = 0, num_checks = 0, n_up, n_ff;
    adc_model #(.PERIOD(4)) adc (.ref_clk(ref_clk), .x_c(x_c), .y_c(y_c), .z_c(z_c),
        .sample_valid(sample_valid), .x_raw(x_raw), .y_raw(y_raw), .z_raw(z_raw));
    // short still run and turn count keep the run brief
    throw_freefall_detector #(.STILL_LEN(4), .TURN_LEN(2)) dut (.ref_clk(ref_clk), .rst(rst),
        .sample_valid(sample_valid), .x_raw(x_raw), .y_raw(y_raw), .z_raw(z_raw),
        .still_thr(STILL_THR_RST), .move_thr(MOVE_THR_RST), .turn_delta(TURN_DELTA_RST),
        .fall_thr(FALL_THR_RST), .stopped_q(stopped_q), .moving_q(moving_q),
        .move_axis_q(move_axis_q), .move_minus_q(move_minus_q), .z_minus_q(z_minus_q),
        .wave_max_q(wave_max_q), .wave_max_valid_q(wave_max_valid_q),
        .composite_q(composite_q), .throw_up_q(throw_up_q), .free_fall_q(free_fall_q));
    initial forever #10 ref_clk = ~ref_clk;
    function automatic int isqrt(int v);
        int r = 0;
        while ((r + 1) * (r + 1) <= v) r++;
        return r;
    endfunction : isqrt
    // next state of the stimulus shift register
    function automatic logic [16:0] lfsr_next(logic [16:0] v);
        return {v[15:0], v[16] ^ v[13]};
    endfunction : lfsr_next
    task automatic check(logic [31:0] seen, logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check
    task automatic give_verdict();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : give_verdict
    // hand one set over, wait for the step, then read the answer while events still stand
    task automatic put(int x, int y, int z);
        x_c = 11'(x);
        y_c = 11'(y);
        z_c = 11'(z);
        @(posedge ref_clk iff sample_valid);
        @(negedge ref_clk);
        check(32'(composite_q), 32'(isqrt(x * x + y * y + z * z)));
        n_up += int'(throw_up_q);
        n_ff += int'(free_fall_q);
    endtask : put
    // small random jitter on x and y stays well inside the stillness limit
    task automatic still(int z);
        lfsr = lfsr_next(lfsr);
        put(int'(lfsr[2:0]), int'(lfsr[5:3]), z);
    endtask : still
    initial begin
        int d, e;
        repeat (6) @(negedge ref_clk);
        rst = 1'b0;
        check(stopped_q, 0);
        check(wave_max_valid_q, 0);
        @(posedge ref_clk iff sample_valid);
        @(negedge ref_clk);
        // throw-up, free-fall, then a fall that ends under gravity with no event
        for (int k = 0; k < 3; k++) begin
            d = (k == 0) ? -1 : 1;
            e = (k == 2) ? 137 : 0;
            n_up = 0;
            n_ff = 0;
            repeat (6) still(0);
            check(stopped_q, 1);
            put(0, 0, d * 40);
            put(0, 0, d * 70);
            check(moving_q, 1);
            check(move_axis_q, 2);
            check(z_minus_q, d < 0);
            check(move_minus_q, d < 0);
            put(0, 0, d * 100);
            if (k == 1) begin
                // shallow dip persists but stays too small to count as a turn-down
                put(0, 0, d * 98);
                put(0, 0, d * 97);
                check(wave_max_valid_q, 0);
                check(moving_q, 1);
            end
            put(0, 0, d * 75);
            put(0, 0, d * 50);
            check(wave_max_valid_q, 1);
            check(32'(wave_max_q), 32'(d * 100));
            repeat (6) still(e);
            check(n_up, d < 0 && e == 0);
            check(n_ff, d > 0 && e == 0);
            check(stopped_q, 1);
            check(32'(wave_max_q), 32'(d * 100));
        end
        // reset in mid-run clears the latched maximum and waits for stillness again
        rst = 1'b1;
        @(negedge ref_clk);
        rst = 1'b0;
        check(32'(wave_max_q), 0);
        check(wave_max_valid_q, 0);
        check(moving_q, 0);
        put(0, 0, 0);
        check(stopped_q, 0);
        give_verdict();
    end
    // cut a hang short well past the expected few hundred cycles
    initial begin
        repeat (20000) @(posedge ref_clk);
        err_count++;
        give_verdict();
    end
endmodule : tb_throw_freefall_detector
